/* File: shared/sfbfe_pkg.sv */
// Shared constants, types and decode helpers for the serial flash bus front end
package sfbfe_pkg;

  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned SYNC_W     = 6;
  localparam logic [5:0]  SYNC_IDLE  = 6'h3d;
  localparam int unsigned SECT_W     = 6;
  localparam int unsigned SECT_LSB   = 12;
  localparam int unsigned BLK64_LSB  = 16;
  localparam int unsigned BLK_W      = 2;
  localparam logic [23:0] ADDR_TOP   = 24'h03ffff;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  OE_OFF     = 4'hf;
  localparam logic [3:0]  OE_SINGLE  = 4'hd;
  localparam logic [3:0]  OE_DUAL    = 4'hc;
  localparam logic [3:0]  OE_QUAD    = 4'h0;
  localparam logic [7:0]  OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0]  OP_DUAL_IO  = 8'hbb;
  localparam logic [7:0]  OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0]  OP_QUAD_IO  = 8'heb;

  typedef enum logic [1:0] {
    K_OPC  = 2'b00,
    K_ADDR = 2'b01,
    K_DATA = 2'b10,
    K_END  = 2'b11
  } sfbfe_kind_type;

  typedef struct packed {
    sfbfe_kind_type kind;
    logic [7:0]     data;
  } sfbfe_rx_type;

  localparam int unsigned RX_W = $bits(sfbfe_rx_type);

  typedef enum logic [1:0] {
    W1 = 2'b00,
    W2 = 2'b01,
    W4 = 2'b10
  } sfbfe_width_type;

  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_OPCODE  = 3'b001,
    PH_ADDR    = 3'b010,
    PH_DUMMY   = 3'b011,
    PH_DIN     = 3'b100,
    PH_DOUT    = 3'b101,
    PH_STANDBY = 3'b110
  } sfbfe_phase_type;

  typedef struct packed {
    logic            known;
    logic            ret;
    logic            strict;
    logic            quad;
    logic            array;
    logic [1:0]      addr_n;
    logic [2:0]      dmy_n;
    sfbfe_width_type addr_w;
    sfbfe_width_type data_w;
  } sfbfe_cmd_type;

  function automatic logic [3:0] width_bits(input sfbfe_width_type w);
    return (w == W4) ? 4'h4 : (w == W2) ? 4'h2 : 4'h1;
  endfunction : width_bits

  function automatic sfbfe_cmd_type decode(input logic [7:0] op);
    sfbfe_cmd_type c;
    c        = '0;
    c.addr_w = W1;
    c.data_w = W1;
    case (op)
      8'h05, 8'h35, 8'h9f:
        c.ret = 1'b1;
      8'h03, 8'h90, 8'hab:
      begin
        c.ret    = 1'b1;
        c.addr_n = 2'h3;
      end
      8'h0b, 8'h48, 8'h5a, 8'h92, 8'h94, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO:
      begin
        c.ret    = 1'b1;
        c.addr_n = 2'h3;
        c.dmy_n  = 3'h1;
      end
      8'h4b:
      begin
        c.ret   = 1'b1;
        c.dmy_n = 3'h4;
      end
      8'h06, 8'h04, 8'h50, 8'h75, 8'hb0, 8'h7a, 8'h30, 8'h66, 8'h99, 8'hb9, 8'h01, 8'h60, 8'hc7:
        c.strict = 1'b1;
      8'h81, 8'h20, 8'h52, 8'hd8, 8'h44, 8'h02, 8'ha2, 8'h32, 8'h42:
      begin
        c.strict = 1'b1;
        c.addr_n = 2'h3;
      end
      default:
        c.addr_n = 2'h0;
    endcase
    c.known = c.ret | c.strict;
    if (op == OP_DUAL_OUT || op == OP_DUAL_IO || op == 8'h92 || op == 8'ha2)
      c.data_w = W2;
    if (op == OP_QUAD_OUT || op == OP_QUAD_IO || op == 8'h94 || op == 8'h32)
    begin
      c.data_w = W4;
      c.quad   = 1'b1;
    end
    if (op == OP_DUAL_IO)
      c.addr_w = W2;
    if (op == OP_QUAD_IO)
      c.addr_w = W4;
    case (op)
      8'h03, 8'h0b, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO,
      8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h02, 8'ha2, 8'h32:
        c.array = 1'b1;
      default:
        c.array = 1'b0;
    endcase
    return c;
  endfunction : decode

endpackage : sfbfe_pkg

/* File: hw/sfbfe_sync.sv */
// Two-stage synchroniser for pins arriving from outside the clk_sys domain
`timescale 1ns/1ns
module sfbfe_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys, // System clock
  input  wire logic         rst_n,   // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output logic      [W-1:0] q        // Synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfbfe_sync_st_type;

  sfbfe_sync_st_type st_ff;
  sfbfe_sync_st_type nxt_st;

  always_comb
  begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      // Start at the pins' idle level so release shows no false edge
      st_ff <= {RST_VAL, RST_VAL};
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.s2;
endmodule : sfbfe_sync

/* File: hw/sfbfe_fifo.sv */
// Byte FIFO between the serial front end and the flash core
`timescale 1ns/1ns
module sfbfe_fifo #(
  parameter int unsigned W     = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         rst_n,     // Async reset, active low
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Space available
  input  wire logic [W-1:0] in_data,   // Write word
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Consumer takes word
  output logic      [W-1:0] out_data   // Oldest word
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             count;
    logic                    nonempty;
    logic [W-1:0]            head;
  } sfbfe_fifo_st_type;

  sfbfe_fifo_st_type st_ff;
  sfbfe_fifo_st_type nxt_st;
  logic              do_wr;
  logic              do_rd;

  assign in_ready  = st_ff.count != (AW+1)'(DEPTH);
  assign out_valid = st_ff.nonempty;
  assign out_data  = st_ff.head;
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (do_wr)
    begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr            = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
    end
    if (do_rd)
      nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
    nxt_st.count = st_ff.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    // Registered head and flag keep the outputs free of decode glitches
    nxt_st.nonempty = nxt_st.count != '0;
    nxt_st.head     = nxt_st.mem[nxt_st.rd];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
endmodule : sfbfe_fifo

/* File: hw/sfbfe_top.sv */
// Serial flash bus front end: lane sampling, command framing, pause and output drive
`timescale 1ns/1ns
module sfbfe_top
  import sfbfe_pkg::*;
(
  input  wire logic                   clk_sys,         // System clock, 250 MHz
  input  wire logic                   rst_n,           // Async reset, active low
  input  wire logic                   sclk_pin,        // Serial clock from host
  input  wire logic                   cs_n_pin,        // Chip select, active low
  input  wire logic [3:0]             lane_in,         // Lane pin levels
  output logic      [3:0]             lane_out,        // Lane drive values
  output logic      [3:0]             lane_oe_n,       // Lane drive enables, active low
  input  wire logic                   quad_enable_bit, // Quad enable status bit
  input  wire logic                   busy,            // Write, program or erase running
  input  wire logic [7:0]             tx_byte,         // Next byte to send
  output logic                        tx_take,         // Pulse: tx_byte consumed
  output logic                        rx_valid,        // Received item available
  input  wire logic                   rx_ready,        // Core takes item
  output sfbfe_pkg::sfbfe_rx_type     rx_data,         // Received item
  output logic                        active,          // Valid command in progress
  output logic                        standby,         // Rejected command, link idle
  output logic [sfbfe_pkg::SECT_W-1:0] sector_idx,     // Sector of last address
  output logic [sfbfe_pkg::BLK_W-1:0]  block64_idx,    // 64K block of last address
  output logic                        overrun          // Sticky: receive byte lost
);
  import sfbfe_pkg::*;

  typedef struct packed {
    sfbfe_phase_type phase;
    sfbfe_cmd_type   cmd;
    logic [7:0]      shreg;
    logic [3:0]      bits;
    logic [1:0]      addr_left;
    logic [2:0]      dmy_left;
    logic [23:0]     addr;
    logic            sclk_prev;
    logic            cs_prev;
    logic            hold_on;
    logic [3:0]      out;
    logic [3:0]      oe_n;
    logic            push_v;
    sfbfe_rx_type    push_d;
    logic            overrun;
    logic            tx_take;
    logic            active;
    logic            standby;
    logic [SECT_W-1:0] sect;
    logic [BLK_W-1:0]  blk;
  } sfbfe_st_type;

  sfbfe_st_type    st_ff;
  sfbfe_st_type    nxt_st;
  logic [SYNC_W-1:0] sync_q;
  logic            sclk_s;
  logic            cs_s;
  logic [3:0]      lanes_s;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            fifo_in_ready;
  logic            hold_en;
  sfbfe_width_type in_w;
  logic [7:0]      sh_new;
  logic [3:0]      cnt;
  sfbfe_cmd_type   info;
  logic            op_done;
  logic            op_reject;

  // Collect sampled lanes MSB first
  function automatic logic [7:0] shift_in(input logic [7:0] s, input sfbfe_width_type w, input logic [3:0] l);
    case (w)
      W2:      return {s[5:0], l[1:0]};
      W4:      return {s[3:0], l};
      default: return {s[6:0], l[0]};
    endcase
  endfunction : shift_in

  // Top bits of a byte onto the lanes
  function automatic logic [3:0] out_group(input logic [7:0] b, input sfbfe_width_type w);
    case (w)
      W2:      return {2'b00, b[7:6]};
      W4:      return b[7:4];
      default: return {2'b00, b[7], 1'b0};
    endcase
  endfunction : out_group

  function automatic logic [3:0] oe_mask(input sfbfe_width_type w);
    return (w == W4) ? OE_QUAD : (w == W2) ? OE_DUAL : OE_SINGLE;
  endfunction : oe_mask

  function automatic sfbfe_phase_type after_addr(input sfbfe_cmd_type c);
    return (c.dmy_n != '0) ? PH_DUMMY : (c.ret ? PH_DOUT : PH_DIN);
  endfunction : after_addr

  // Queue one item; a second before drain counts as loss
  function automatic sfbfe_st_type push(input sfbfe_st_type s, input sfbfe_kind_type k, input logic [7:0] d);
    sfbfe_st_type r;
    r              = s;
    r.overrun      = s.overrun | s.push_v;
    r.push_v       = 1'b1;
    r.push_d.kind  = k;
    r.push_d.data  = d;
    return r;
  endfunction : push

  sfbfe_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_IDLE)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({lane_in, sclk_pin, cs_n_pin}),
    .q       (sync_q)
  );

  assign cs_s    = sync_q[0];
  assign sclk_s  = sync_q[1];
  assign lanes_s = sync_q[5:2];
  assign sclk_rise = sclk_s && !st_ff.sclk_prev;
  assign sclk_fall = !sclk_s && st_ff.sclk_prev;
  assign hold_en = !(st_ff.cmd.quad && st_ff.phase != PH_OPCODE && st_ff.phase != PH_IDLE);

  assign in_w = (st_ff.phase == PH_ADDR || st_ff.phase == PH_DUMMY) ? st_ff.cmd.addr_w :
                (st_ff.phase == PH_DIN) ? st_ff.cmd.data_w : W1;
  assign sh_new = shift_in(st_ff.shreg, in_w, lanes_s);
  assign cnt    = st_ff.bits + width_bits(in_w);
  assign info   = decode(sh_new);
  assign op_done = !cs_s && !st_ff.cs_prev && !st_ff.hold_on && sclk_rise &&
                   st_ff.phase == PH_OPCODE && cnt == BYTE_BITS;
  assign op_reject = !info.known || (info.quad && !quad_enable_bit) || (info.array && busy);

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.sclk_prev = sclk_s;
    nxt_st.cs_prev   = cs_s;
    nxt_st.tx_take   = 1'b0;
    if (st_ff.push_v && fifo_in_ready)
      nxt_st.push_v = 1'b0;
    if (cs_s)
    begin
      if (st_ff.active)
        nxt_st = push(nxt_st, K_END, {7'h00, !(st_ff.cmd.strict && st_ff.bits != '0)});
      nxt_st.phase   = PH_IDLE;
      nxt_st.bits    = '0;
      nxt_st.hold_on = 1'b0;
      nxt_st.active  = 1'b0;
      nxt_st.cmd     = '0;
    end
    else if (st_ff.cs_prev)
    begin
      nxt_st.phase = PH_OPCODE;
      nxt_st.bits  = '0;
      nxt_st.cmd   = '0;
    end
    else if (st_ff.phase != PH_STANDBY)
    begin
      if (hold_en && !sclk_s)
        nxt_st.hold_on = !lanes_s[3];
      if (!st_ff.hold_on && sclk_rise && st_ff.phase != PH_DOUT)
      begin
        nxt_st.shreg = sh_new;
        nxt_st.bits  = cnt;
        if (cnt == BYTE_BITS)
        begin
          nxt_st.bits = '0;
          case (st_ff.phase)
            PH_OPCODE:
              if (op_reject)
                nxt_st.phase = PH_STANDBY;
              else
              begin
                nxt_st           = push(nxt_st, K_OPC, sh_new);
                nxt_st.active    = 1'b1;
                nxt_st.cmd       = info;
                nxt_st.addr_left = info.addr_n;
                nxt_st.dmy_left  = info.dmy_n;
                nxt_st.phase     = (info.addr_n != '0) ? PH_ADDR : after_addr(info);
              end
            PH_ADDR:
            begin
              nxt_st           = push(nxt_st, K_ADDR, sh_new);
              nxt_st.addr      = {st_ff.addr[15:0], sh_new};
              nxt_st.addr_left = st_ff.addr_left - 2'h1;
              if (st_ff.addr_left == 2'h1)
              begin
                nxt_st.sect  = nxt_st.addr[SECT_LSB +: SECT_W] & ADDR_TOP[SECT_LSB +: SECT_W];
                nxt_st.blk   = nxt_st.addr[BLK64_LSB +: BLK_W] & ADDR_TOP[BLK64_LSB +: BLK_W];
                nxt_st.phase = after_addr(st_ff.cmd);
              end
            end
            PH_DUMMY:
            begin
              nxt_st.dmy_left = st_ff.dmy_left - 3'h1;
              if (st_ff.dmy_left == 3'h1)
                nxt_st.phase = st_ff.cmd.ret ? PH_DOUT : PH_DIN;
            end
            PH_DIN:
              nxt_st = push(nxt_st, K_DATA, sh_new);
            default:
              nxt_st.bits = '0;
          endcase
        end
      end
      if (!st_ff.hold_on && sclk_fall && st_ff.phase == PH_DOUT)
      begin
        if (st_ff.bits == '0)
        begin
          nxt_st.tx_take = 1'b1;
          nxt_st.out     = out_group(tx_byte, st_ff.cmd.data_w);
          nxt_st.shreg   = tx_byte << width_bits(st_ff.cmd.data_w);
          nxt_st.bits    = BYTE_BITS - width_bits(st_ff.cmd.data_w);
        end
        else
        begin
          nxt_st.out   = out_group(st_ff.shreg, st_ff.cmd.data_w);
          nxt_st.shreg = st_ff.shreg << width_bits(st_ff.cmd.data_w);
          nxt_st.bits  = st_ff.bits - width_bits(st_ff.cmd.data_w);
        end
      end
    end
    nxt_st.oe_n = (nxt_st.phase == PH_DOUT && !(hold_en && !lanes_s[3])) ?
                  oe_mask(nxt_st.cmd.data_w) : OE_OFF;
    nxt_st.standby = nxt_st.phase == PH_STANDBY;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff         <= '0;
      st_ff.cs_prev <= 1'b1;
      st_ff.oe_n    <= OE_OFF;
    end
    else
      st_ff <= nxt_st;
  end

  // Back-pressure holds one item; busy cores may still lose bytes, flagged as overrun
  sfbfe_fifo #(
    .W     (RX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (st_ff.push_v),
    .in_ready  (fifo_in_ready),
    .in_data   (st_ff.push_d),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  assign lane_out    = st_ff.out;
  assign lane_oe_n   = st_ff.oe_n;
  assign tx_take     = st_ff.tx_take;
  assign active      = st_ff.active;
  assign standby     = st_ff.standby;
  assign sector_idx  = st_ff.sect;
  assign block64_idx = st_ff.blk;
  assign overrun     = st_ff.overrun;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence cs_rise_s;
    cs_s && !st_ff.cs_prev;
  endsequence

  standby_float_a: assert property (st_ff.phase == PH_STANDBY |-> st_ff.oe_n == OE_OFF)
    else $error("pins driven in standby");
  standby_stays_a: assert property (st_ff.phase == PH_STANDBY && !cs_s |=> st_ff.phase == PH_STANDBY && !st_ff.active)
    else $error("standby left before select rise");
  reject_standby_a: assert property (op_done && op_reject |=> st_ff.standby && !st_ff.active)
    else $error("bad opcode not rejected");
  quad_gate_a: assert property (op_done && info.quad && !quad_enable_bit |=> st_ff.phase == PH_STANDBY)
    else $error("quad command taken without enable");
  busy_gate_a: assert property (op_done && info.array && busy |=> !st_ff.active)
    else $error("array access taken while busy");
  active_holds_a: assert property (st_ff.active && !cs_s |=> st_ff.active)
    else $error("active dropped inside frame");
  take_on_fall_a: assert property (st_ff.tx_take |-> $past(sclk_fall) && st_ff.phase == PH_DOUT)
    else $error("output advanced off falling edge");
  strict_drop_a: assert property (cs_s && st_ff.active && st_ff.cmd.strict && st_ff.bits != '0
                                  |=> st_ff.push_v && st_ff.push_d.kind == K_END && !st_ff.push_d.data[0])
    else $error("partial byte command not discarded");
  hold_float_a: assert property (!cs_s && hold_en && !lanes_s[3] |=> st_ff.oe_n == OE_OFF)
    else $error("output driven while paused");
  hold_ignore_a: assert property (st_ff.hold_on && !cs_s |=> $stable(st_ff.bits) && $stable(st_ff.phase))
    else $error("input taken during pause");
  quad_no_hold_a: assert property (!hold_en |-> !st_ff.hold_on)
    else $error("pause active in quad mode");
  cs_reset_a: assert property (cs_rise_s ##1 cs_s |-> st_ff.phase == PH_IDLE && !st_ff.hold_on)
    else $error("select rise did not reset link");
endmodule : sfbfe_top

/* File: testbench/sfbfe_host_model.sv */
// Host serial controller model: clock, select and lane drive
`timescale 1ns/1ns
module sfbfe_host_model (
  input  wire logic       clk_sys,   // Pacing clock
  output logic            sclk,      // Serial clock
  output logic            cs_n,      // Chip select, active low
  output logic [3:0]      lane,      // Resolved lane levels
  input  wire logic [3:0] lane_out,  // Device drive values
  input  wire logic [3:0] lane_oe_n  // Device enables, active low
);
  logic       clock_polarity;
  logic       hold_n;
  logic [3:0] drv_en;
  logic [3:0] drv_v;

  // Board pull-ups hold released lanes high; lane_3 idles at the pause level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      lane[i] = !lane_oe_n[i] ? lane_out[i] : drv_en[i] ? drv_v[i] : (i == 3) ? hold_n : 1'b1;
  end

  initial
  begin
    clock_polarity   = 1'b0;
    hold_n = 1'b1;
    drv_en = 4'h0;
    drv_v  = 4'h0;
    cs_n   = 1'b1;
    sclk   = 1'b0;
  end

  // Half a link period: 16 ns
  task automatic half();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : half

  task automatic open_frame(input logic pol);
    clock_polarity = pol;
    sclk = pol;
    half();
    cs_n = 1'b0;
    half();
  endtask : open_frame

  // drive on fall, capture on rise
  task automatic shift(input logic [7:0] tx, input int w, input bit drv, input int steps, output logic [7:0] rx);
    logic [7:0] t;
    t  = tx;
    rx = 8'h00;
    for (int s = 0; s < steps; s++)
    begin
      sclk   = 1'b0;
      drv_en = !drv ? 4'h0 : (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
      drv_v  = (w == 1) ? {3'b000, t[7]} : (w == 2) ? {2'b00, t[7:6]} : t[7:4];
      half();
      sclk = 1'b1;
      rx   = (w == 1) ? {rx[6:0], lane[1]} : (w == 2) ? {rx[5:0], lane[1:0]} : {rx[3:0], lane};
      t    = t << w;
      half();
    end
  endtask : shift

  // select rises with clock at idle level
  task automatic close_frame();
    drv_en = 4'h0;
    sclk   = clock_polarity;
    half();
    cs_n = 1'b1;
    half();
  endtask : close_frame

  // pause pin moved while clock may be high
  task automatic set_hold(input logic v);
    hold_n = v;
    half();
  endtask : set_hold
endmodule : sfbfe_host_model

/* File: testbench/serial_flash_bus_front_end_test.sv */
// Self-checking bench for the serial flash bus front end
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module serial_flash_bus_front_end_test;
  import sfbfe_pkg::*;
  logic                clk_sys;
  logic                rst_n;
  logic                sclk_pin;
  logic                cs_n_pin;
  logic [3:0]          lane;
  logic [3:0]          lane_out;
  logic [3:0]          lane_oe_n;
  logic                quad_enable_bit;
  logic                busy;
  logic [7:0]          tx_byte;
  logic                tx_take;
  logic                rx_valid;
  logic                rx_ready;
  sfbfe_rx_type        rx_data;
  logic                active;
  logic                standby;
  logic [SECT_W-1:0]   sector_idx;
  logic [BLK_W-1:0]    block64_idx;
  logic                overrun;
  logic                chk_en;
  int                  errors;
  int                  n_tests;
  int                  cyc;
  int                  takes;
  sfbfe_rx_type        exp_item;
  sfbfe_rx_type        exp_q[$];

  sfbfe_host_model u_host (.clk_sys(clk_sys), .sclk(sclk_pin), .cs_n(cs_n_pin), .lane(lane),
                           .lane_out(lane_out), .lane_oe_n(lane_oe_n));
  sfbfe_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .lane_in(lane),
                 .lane_out(lane_out), .lane_oe_n(lane_oe_n), .quad_enable_bit(quad_enable_bit), .busy(busy),
                 .tx_byte(tx_byte), .tx_take(tx_take), .rx_valid(rx_valid), .rx_ready(rx_ready),
                 .rx_data(rx_data), .active(active), .standby(standby), .sector_idx(sector_idx),
                 .block64_idx(block64_idx), .overrun(overrun));

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  task automatic close_out();
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Test length is a few thousand cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      close_out();
    end
  end

  // Oldest note against each item taken, looked at while it still stands; a surplus item meets x
  always @(negedge clk_sys)
    if (rx_valid === 1'b1 && rx_ready === 1'b1 && chk_en === 1'b1)
    begin
      exp_item = 'x;
      if (exp_q.size() != 0)
        exp_item = exp_q.pop_front();
      `CHK(rx_data, exp_item)
    end

  always @(negedge clk_sys)
    if (tx_take === 1'b1)
      takes++;

  task automatic note(input sfbfe_kind_type k, input logic [7:0] d);
    exp_q.push_back({k, d});
  endtask : note

  task automatic op(input logic [7:0] b);
    logic [7:0] d;
    u_host.shift(b, 1, 1'b1, 8, d);
  endtask : op

  task automatic do_reset();
    rst_n = 1'b0;
    exp_q.delete();
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n  = 1'b1;
    chk_en = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : do_reset

  initial
  begin
    logic [7:0]  r;
    logic [23:0] a;
    logic [7:0]  code [4];
    int          aw [4];
    int          dw [4];
    code = '{OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO};
    aw   = '{1, 2, 1, 4};
    dw   = '{2, 2, 4, 4};
    rx_ready = 1'b1;
    void'($urandom(32'h87d7));
    quad_enable_bit = 1'($urandom);
    busy            = 1'($urandom);
    do_reset();
    // Status read first, in both clock modes, second one while busy, cut short mid byte
    for (int m = 0; m < 2; m++)
    begin
      tx_byte = 8'($urandom);
      busy    = m[0];
      takes   = 0;
      u_host.open_frame(m[0]);
      op(8'h05);
      note(K_OPC, 8'h05);
      u_host.shift(8'h00, 1, 1'b0, 8, r);
      `CHK(r, tx_byte)
      `CHK(active, 1'b1)
      u_host.shift(8'h00, 1, 1'b0, 3, r);
      u_host.close_frame();
      note(K_END, 8'h01);
      `CHK(lane_oe_n, OE_OFF)
      `CHK(active, 1'b0)
      `CHK(takes, 2)
    end
    // Unknown, quad without enable, array while busy: later opcode ignored
    for (int k = 0; k < 3; k++)
    begin
      busy            = (k == 0);
      quad_enable_bit = (k != 1);
      u_host.open_frame(1'b0);
      op((k == 2) ? 8'hff : (k == 1) ? OP_QUAD_OUT : 8'h03);
      op(8'h05);
      `CHK(standby, 1'b1)
      `CHK(lane_oe_n, OE_OFF)
      `CHK(active, 1'b0)
      u_host.close_frame();
      `CHK(standby, 1'b0)
    end
    // Control command whole, then with three extra bits
    for (int k = 0; k < 2; k++)
    begin
      u_host.open_frame(1'b0);
      op(8'h06);
      note(K_OPC, 8'h06);
      if (k == 1)
        u_host.shift(8'($urandom), 1, 1'b1, 3, r);
      u_host.close_frame();
      note(K_END, (k == 0) ? 8'h01 : 8'h00);
    end
    // Read with pause across the address, pin moved while clock high
    tx_byte = 8'($urandom);
    a       = 24'($urandom);
    u_host.open_frame(1'b0);
    op(8'h03);
    note(K_OPC, 8'h03);
    op(a[23:16]);
    note(K_ADDR, a[23:16]);
    u_host.set_hold(1'b0);
    u_host.shift(8'($urandom), 1, 1'b1, 5, r);
    u_host.set_hold(1'b1);
    note(K_ADDR, a[15:8]);
    op(a[15:8]);
    note(K_ADDR, a[7:0]);
    op(a[7:0]);
    u_host.shift(8'h00, 1, 1'b0, 8, r);
    `CHK(r, tx_byte)
    `CHK(sector_idx, a[17:12])
    `CHK(block64_idx, a[17:16])
    u_host.set_hold(1'b0);
    `CHK(lane_oe_n, OE_OFF)
    `CHK(exp_q.size(), 0)
    chk_en = 1'b0;
    u_host.close_frame();
    u_host.set_hold(1'b1);
    tx_byte = 8'($urandom);
    u_host.open_frame(1'b0);
    op(8'h05);
    u_host.shift(8'h00, 1, 1'b0, 8, r);
    `CHK(r, tx_byte)
    `CHK(active, 1'b1)
    u_host.close_frame();
    do_reset();
    // Dual and quad reads; quad address drives the pause lane
    chk_en = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      tx_byte = 8'($urandom);
      a       = 24'($urandom);
      u_host.open_frame(1'b0);
      op(code[k]);
      for (int b = 2; b >= 0; b--)
        u_host.shift(a[8*b +: 8], aw[k], 1'b1, 8 / aw[k], r);
      u_host.shift(8'h00, aw[k], 1'b1, 8 / aw[k], r);
      u_host.shift(8'h00, dw[k], 1'b0, 8 / dw[k], r);
      `CHK(r, tx_byte)
      `CHK(sector_idx, a[17:12])
      u_host.close_frame();
    end
    // Long program with the core stalled overruns the buffer
    rx_ready = 1'b0;
    u_host.open_frame(1'b0);
    op(8'h02);
    repeat (19) op(8'($urandom));
    u_host.close_frame();
    `CHK(overrun, 1'b1)
    `CHK(rx_valid, 1'b1)
    rx_ready = 1'b1;
    repeat (40) @(posedge clk_sys);
    #1;
    `CHK(rx_valid, 1'b0)
    do_reset();
    close_out();
  end
endmodule : serial_flash_bus_front_end_test
